// *** hdl/adc_ctrl_pkg.sv ***
// Purpose: Shared constants for the converter control block.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes: Byte-wide registers sit in the low bits of each word.
package adc_ctrl_pkg;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFS_CHANNEL_RUN = 8'h08;
  localparam logic [7:0] OFS_TIMING_CFG = 8'h0C;
  localparam logic [7:0] OFS_SHARED_SEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_POWER_MODE = 8'h18;
  // Channel and run control fields.
  localparam int BIT_CONVERTER_ON = 0;
  localparam int BIT_START = 1;
  localparam int CHAN_LSB = 2;
  // Timing configuration fields.
  localparam int BIT_FORMAT = 7;
  localparam int BIT_CALIBRATE = 6;
  localparam int ACQ_LSB = 3;
  localparam int CLK_LSB = 0;
  // Shared register select sits at bit 4 of the watchdog control word.
  localparam int BIT_SHARED_SEL = 4;
  localparam int BIT_DONE_FLAG = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] PIN_CFG_LOW_MASK = 8'h9F;
  localparam logic [7:0] PIN_CFG_HIGH_MASK = 8'hFC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Instruction cycle is four system clocks; RC period is 4 us.
  localparam int INSTR_CYCLE_CLKS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_PERIOD_NS = 4000;
  localparam int RC_DIVIDE = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BITS_PER_CONVERSION = 11;
  localparam int POST_WAIT_PERIODS = 2;
  localparam logic [2:0] CLK_RC_LOW = 3'h3;
endpackage : adc_ctrl_pkg

// *** hdl/adc_tick_gen.sv ***
// Purpose: Produces one pulse per bit conversion period from the selected source.
// Assumes: System clock is the oscillator; RC source is a divider of it.
// Notes: Encoding 000,100,001,101,010,110 -> 2,4,8,16,32,64 periods; x11 -> RC.
`timescale 1ns/1ps
`default_nettype none
module adc_tick_gen (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] clockSelect,
  output logic tick
);
  logic [8:0] count_reg;
  logic [8:0] limit;
  wire isRc = (clockSelect[1:0] == adc_ctrl_pkg::CLK_RC_LOW[1:0]);
  wire [2:0] shiftAmt = {clockSelect[1:0], clockSelect[2]};
  assign limit = isRc ? 9'(adc_ctrl_pkg::RC_DIVIDE - 1) : 9'((9'h002 << shiftAmt) - 9'h001);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 9'h000;
    end else if (!run || count_reg >= limit) begin
      count_reg <= 9'h000;
    end else begin
      count_reg <= count_reg + 9'h001;
    end
  end
  assign tick = run && (count_reg >= limit);
endmodule : adc_tick_gen
`default_nettype wire

// *** hdl/adc_result_format.sv ***
// Purpose: Arranges the ten-bit result into high and low bytes.
// Assumes: Format bit one means right justified.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module adc_result_format (
  input wire logic [9:0] sample,
  input wire logic rightJustify,
  output logic [7:0] highByte,
  output logic [7:0] lowByte
);
  assign highByte = rightJustify ? {6'h00, sample[9:8]} : sample[9:2];
  assign lowByte = rightJustify ? sample[7:0] : {sample[1:0], 6'h00};
endmodule : adc_result_format
`default_nettype wire

// *** hdl/adc_power_mode_ctrl.sv ***
// Purpose: Converter sequencing, calibration and shared register map over AXI4-Lite.
// Assumes: Analog sample arrives on analogSample; power mode signals come from the core.
// Notes: Writes and reads answer one cycle after both halves are present.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Start accepted once a power-managed Run mode is entered.
// - Conversion continues if core enters Idle mid-conversion.
// - Zero acquisition field delays conversion start by one instruction cycle.
// - Device clears start when dummy conversion ends; firmware polls it.
// - Pin configuration registers visible only with shared select set.
// - Shared select clear maps addresses to default control registers.
// - Result shown as high and low bytes per format bit.
// - Timing choices count in whatever clock the mode supplies.
// - On finish: clear start, set done flag, resume sampling two periods later.
// - Clock field encodes 2..64 oscillator periods or RC clock.
// - Calibrating start converts no input and stores offset correction.
module adc_power_mode_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] analogSample,
  output logic [3:0] sampleChannel,
  output logic sampleEnable
);
  typedef enum logic [2:0] {IDLE, ACQUIRE, CONVERT, POSTWAIT} state_t;
  state_t state_reg, state_next;
  logic [7:0] chanRun_reg, timing_reg, pinLow_reg, pinHigh_reg, wdt_reg, power_reg;
  logic [7:0] resHigh_reg, resLow_reg;
  logic done_reg, offsetValid_reg;
  logic [9:0] offset_reg;
  logic [3:0] bitCount_reg;
  logic [2:0] acqCount_reg;
  logic [1:0] delay_reg;
  logic calActive_reg;
  logic [1:0] postCount_reg;
  logic awSeen_reg, wSeen_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  // Power mode word: bit0 run mode, bit1 idle, bit2 sleep (core status mirror).
  wire sharedSel = wdt_reg[adc_ctrl_pkg::BIT_SHARED_SEL];
  wire converterOn = chanRun_reg[adc_ctrl_pkg::BIT_CONVERTER_ON];
  wire startFlag = chanRun_reg[adc_ctrl_pkg::BIT_START];
  wire [2:0] acqSel = timing_reg[adc_ctrl_pkg::ACQ_LSB +: 3];
  wire [2:0] clkSel = timing_reg[adc_ctrl_pkg::CLK_LSB +: 3];
  wire calibrate = timing_reg[adc_ctrl_pkg::BIT_CALIBRATE];
  wire tick;
  wire busy = (state_reg != IDLE);
  adc_tick_gen tickGen (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(busy),
    .clockSelect(clkSel),
    .tick(tick)
  );
  wire [9:0] corrected = (analogSample > offset_reg) ? (analogSample - offset_reg) : 10'h000;
  wire [7:0] fmtHigh, fmtLow;
  adc_result_format fmt (
    .sample(corrected),
    .rightJustify(timing_reg[adc_ctrl_pkg::BIT_FORMAT]),
    .highByte(fmtHigh),
    .lowByte(fmtLow)
  );
  // Write path: address and data may arrive in either order.
  wire wrFire = awSeen_reg && wSeen_reg && !s_axi_bvalid;
  wire wrHigh = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_RESULT_HIGH);
  wire wrLow = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_RESULT_LOW);
  wire wrCtl = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_CHANNEL_RUN);
  wire wrTim = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_TIMING_CFG);
  wire wrWdt = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_SHARED_SEL);
  wire wrSts = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_STATUS);
  wire wrPwr = wrFire && (awAddr_reg == adc_ctrl_pkg::OFS_POWER_MODE);
  wire wrMapped = wrHigh || wrLow || wrCtl || wrTim || wrWdt || wrSts || wrPwr;
  wire wrByte = wStrb_reg[0];
  wire [7:0] wByte = wData_reg[7:0];
  wire wrPinLow = wrCtl && sharedSel && wrByte;
  wire wrPinHigh = wrTim && sharedSel && wrByte;
  wire wrCtlDef = wrCtl && !sharedSel && wrByte;
  wire wrTimDef = wrTim && !sharedSel && wrByte;
  // start needs a run, idle or sleep mode bit and converter on
  wire runMode = power_reg[0] || power_reg[1] || power_reg[2];
  wire startReq = wrCtlDef && wByte[adc_ctrl_pkg::BIT_START] && !startFlag && converterOn && runMode;
  wire abortReq = wrCtlDef && !wByte[adc_ctrl_pkg::BIT_START] && busy;
  wire convEnd = (state_reg == CONVERT) && tick && (bitCount_reg == 4'(adc_ctrl_pkg::BITS_PER_CONVERSION - 1));
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE: if (startReq) state_next = ACQUIRE;
      ACQUIRE: if (delay_reg == 2'h0 && (acqSel == 3'h0 || (tick && acqCount_reg <= 3'h1))) state_next = CONVERT;
      CONVERT: if (convEnd) state_next = POSTWAIT;
      POSTWAIT: if (tick && postCount_reg == 2'(adc_ctrl_pkg::POST_WAIT_PERIODS - 1)) state_next = IDLE;
      default: state_next = IDLE;
    endcase
    if (abortReq) state_next = POSTWAIT;
  end
  // idle and sleep do not gate the sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // acquisition, bit and post-wait counts advance on the selected period tick; the start delay counts system clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acqCount_reg <= 3'h0;
      bitCount_reg <= 4'h0;
      postCount_reg <= 2'h0;
      delay_reg <= 2'h0;
      calActive_reg <= 1'b0;
    end else begin
      if (startReq) begin
        acqCount_reg <= acqSel;
        delay_reg <= (acqSel == 3'h0) ? 2'(adc_ctrl_pkg::INSTR_CYCLE_CLKS - 1) : 2'h0;
        calActive_reg <= calibrate;
      end else if (state_reg == ACQUIRE) begin
        if (delay_reg != 2'h0) delay_reg <= delay_reg - 2'h1;
        if (tick && acqCount_reg != 3'h0) acqCount_reg <= acqCount_reg - 3'h1;
      end
      bitCount_reg <= (state_reg != CONVERT) ? 4'h0 : (tick ? bitCount_reg + 4'h1 : bitCount_reg);
      postCount_reg <= (state_reg != POSTWAIT) ? 2'h0 : (tick ? postCount_reg + 2'h1 : postCount_reg);
    end
  end
  // Register file; start flag set by start, cleared at end.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chanRun_reg <= adc_ctrl_pkg::RESET_BYTE;
      timing_reg <= adc_ctrl_pkg::RESET_BYTE;
      pinLow_reg <= adc_ctrl_pkg::RESET_BYTE;
      pinHigh_reg <= adc_ctrl_pkg::RESET_BYTE;
      wdt_reg <= adc_ctrl_pkg::RESET_BYTE;
      power_reg <= adc_ctrl_pkg::RESET_BYTE;
    end else begin
      if (wrCtlDef) begin
        chanRun_reg <= {wByte[7:2], startReq || (busy && !abortReq), wByte[0]};
      end else if (convEnd) begin
        chanRun_reg[adc_ctrl_pkg::BIT_START] <= 1'b0;
      end
      if (wrTimDef) timing_reg <= wByte;
      if (wrPinLow) pinLow_reg <= wByte & adc_ctrl_pkg::PIN_CFG_LOW_MASK;
      if (wrPinHigh) pinHigh_reg <= wByte & adc_ctrl_pkg::PIN_CFG_HIGH_MASK;
      if (wrWdt && wrByte) wdt_reg <= wByte;
      if (wrPwr && wrByte) power_reg <= {5'h00, wByte[2:0]};
    end
  end
  // Result registers keep the last completed value on abort.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resHigh_reg <= adc_ctrl_pkg::RESET_BYTE;
      resLow_reg <= adc_ctrl_pkg::RESET_BYTE;
      offset_reg <= 10'h000;
      offsetValid_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (convEnd && calActive_reg) begin
        offset_reg <= analogSample;
        offsetValid_reg <= 1'b1;
      end else if (convEnd) begin
        resHigh_reg <= fmtHigh;
        resLow_reg <= fmtLow;
      end else begin
        if (wrHigh && wrByte) resHigh_reg <= wByte;
        if (wrLow && wrByte) resLow_reg <= wByte;
      end
      // done flag, set wins over clear
      if (convEnd) done_reg <= 1'b1;
      else if (wrSts && wrByte && wByte[adc_ctrl_pkg::BIT_DONE_FLAG]) done_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sampleChannel <= 4'h0;
      sampleEnable <= 1'b0;
    end else begin
      sampleChannel <= chanRun_reg[adc_ctrl_pkg::CHAN_LSB +: 4];
      sampleEnable <= converterOn && (state_next == IDLE || state_next == ACQUIRE) && !(startReq && calibrate);
    end
  end
  // AXI write channel handling.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awSeen_reg <= 1'b0;
      wSeen_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_ctrl_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSeen_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wSeen_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awSeen_reg <= 1'b0;
        wSeen_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awSeen_reg && !s_axi_bvalid;
  assign s_axi_wready = !wSeen_reg && !s_axi_bvalid;
  // AXI read path.
  wire [7:0] rdCtl = sharedSel ? pinLow_reg : chanRun_reg;
  wire [7:0] rdTim = sharedSel ? pinHigh_reg : timing_reg;
  logic [7:0] rdByte;
  logic rdOk;
  always_comb begin
    rdByte = 8'h00;
    rdOk = 1'b1;
    unique case (s_axi_araddr)
      adc_ctrl_pkg::OFS_RESULT_HIGH: rdByte = resHigh_reg;
      adc_ctrl_pkg::OFS_RESULT_LOW: rdByte = resLow_reg;
      adc_ctrl_pkg::OFS_CHANNEL_RUN: rdByte = rdCtl;
      adc_ctrl_pkg::OFS_TIMING_CFG: rdByte = rdTim;
      adc_ctrl_pkg::OFS_SHARED_SEL: rdByte = wdt_reg;
      adc_ctrl_pkg::OFS_STATUS: rdByte = {5'h00, offsetValid_reg, busy, done_reg};
      adc_ctrl_pkg::OFS_POWER_MODE: rdByte = power_reg;
      default: rdOk = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adc_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdOk ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // Assertions.
  a_start_held_busy: assert property (@(posedge sys_clk) disable iff (rst) busy && !convEnd && state_reg != POSTWAIT |-> startFlag) else $error("start flag dropped while busy");
  a_end_sets_done: assert property (@(posedge sys_clk) disable iff (rst) convEnd |=> done_reg && !startFlag) else $error("end did not set done");
  a_zero_acq_delay: assert property (@(posedge sys_clk) disable iff (rst) startReq && acqSel == 3'h0 |=> state_reg == ACQUIRE [*3]) else $error("zero acquisition not delayed");
  a_start_needs_run: assert property (@(posedge sys_clk) disable iff (rst) $rose(busy) |-> $past(runMode) && $past(converterOn)) else $error("start without run mode");
  a_cal_keeps_result: assert property (@(posedge sys_clk) disable iff (rst) convEnd && calActive_reg && !wrHigh |=> $stable(resHigh_reg)) else $error("calibration touched result");
  a_shared_hides_ctl: assert property (@(posedge sys_clk) disable iff (rst) wrCtl && sharedSel |=> $stable(chanRun_reg) || convEnd) else $error("shared write hit control");
  a_default_map_ctl: assert property (@(posedge sys_clk) disable iff (rst) wrTim && !sharedSel && wrByte |=> timing_reg == $past(wByte)) else $error("default map write lost");
  // The slowest bit period is the RC one, so a tick must come within that many cycles.
  a_idle_no_stall: assert property (@(posedge sys_clk) disable iff (rst) state_reg == CONVERT && power_reg[1] |-> ##[0:400] (tick || state_reg != CONVERT)) else $error("conversion stalled in idle");
  a_format_right: assert property (@(posedge sys_clk) disable iff (rst) convEnd && !calActive_reg && timing_reg[7] |=> resHigh_reg[7:2] == 6'h00) else $error("right format wrong");
endmodule : adc_power_mode_ctrl
`default_nettype wire

// *** dv/adc_analog_source.sv ***
// Purpose: Stands in for the analog input pins feeding the sampling converter.
// Assumes: Every channel carries a steady level distinct from its neighbours.
// Notes: An analog pin is never released, so the level is driven at all times.
`timescale 1ns/1ps
`default_nettype none
module adc_analog_source (
  input wire logic [3:0] sampleChannel,
  input wire logic sampleEnable,
  output logic [9:0] analogSample
);
  // The low bits differ by channel so a wrong channel or a swapped byte shows up.
  assign analogSample = {sampleChannel, 6'h2D ^ {2'h0, sampleChannel}};
endmodule : adc_analog_source
`default_nettype wire

// *** dv/adc_power_mode_and_calibration_control_test.sv ***
// Purpose: Self-checking bench for the converter control block.
// Assumes: Register access over AXI4-Lite, byte registers in bits 7:0.
// Notes: Ready signals are looked at on the falling edge, where they have settled.
`timescale 1ns/1ps
`default_nettype none
module adc_power_mode_and_calibration_control_test;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  wire logic awready, wready, bvalid, arready, rvalid, sampleEnable;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0] analogSample;
  wire logic [3:0] sampleChannel;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  always #5 sys_clk = ~sys_clk;
  adc_power_mode_ctrl dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .analogSample(analogSample),
    .sampleChannel(sampleChannel), .sampleEnable(sampleEnable));
  adc_analog_source pins (.sampleChannel(sampleChannel), .sampleEnable(sampleEnable),
    .analogSample(analogSample));
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // A hang anywhere lands here after a generous ceiling.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done = checks_done + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge sys_clk);
      aw = aw || awready;
      w = w || wready;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    do begin
      @(negedge sys_clk);
      r = bresp;
      aw = bvalid;
      @(posedge sys_clk);
    end while (!aw);
    bready <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      got = arready;
      @(posedge sys_clk);
    end while (!got);
    arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
    end while (!got);
    rready <= 1'b0;
  endtask : rdreg
  // Polls the start bit until it drops; returns elapsed cycles.
  task automatic wait_idle(output int took);
    int t0;
    t0 = cyc;
    do rdreg(adc_ctrl_pkg::OFS_CHANNEL_RUN, rd, rsp);
    while (rd[adc_ctrl_pkg::BIT_START] === 1'b1 && cyc - t0 < 20000);
    took = cyc - t0;
  endtask : wait_idle
  task automatic reset_and_map;
    for (int i = 0; i < 7; i++) begin
      rdreg(8'(4 * i), rd, rsp);
      check(rd, 32'h0);
      check(32'(rsp), 32'(adc_ctrl_pkg::RESP_OKAY));
    end
    rdreg(8'h1C, rd, rsp);
    check(32'(rsp), 32'(adc_ctrl_pkg::RESP_SLVERR));
    wr(8'h1C, 8'hFF, rsp);
    check(32'(rsp), 32'(adc_ctrl_pkg::RESP_SLVERR));
  endtask : reset_and_map
  task automatic shared_map;
    // pin bit cleared inside the shared-select bracket.
    wr(adc_ctrl_pkg::OFS_SHARED_SEL, 8'h10, rsp);
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, 8'hFE, rsp);
    wr(adc_ctrl_pkg::OFS_TIMING_CFG, 8'hFF, rsp);
    rdreg(adc_ctrl_pkg::OFS_CHANNEL_RUN, rd, rsp);
    check(rd, {24'h0, 8'hFE & adc_ctrl_pkg::PIN_CFG_LOW_MASK});
    rdreg(adc_ctrl_pkg::OFS_TIMING_CFG, rd, rsp);
    check(rd, {24'h0, adc_ctrl_pkg::PIN_CFG_HIGH_MASK});
    wr(adc_ctrl_pkg::OFS_SHARED_SEL, 8'h00, rsp);
    rdreg(adc_ctrl_pkg::OFS_CHANNEL_RUN, rd, rsp);
    check(rd, 32'h0);
    rdreg(adc_ctrl_pkg::OFS_TIMING_CFG, rd, rsp);
    check(rd, 32'h0);
  endtask : shared_map
  // Converts channel ch with the given timing byte and checks both result bytes.
  task automatic convert(input logic [3:0] ch, input logic [7:0] timing, input logic [1:0] mode,
                         output int took);
    logic [9:0] s;
    int t0;
    s = {ch, 6'h2D ^ {2'h0, ch}};
    // timing fields set for the mode clock before start.
    wr(adc_ctrl_pkg::OFS_TIMING_CFG, timing, rsp);
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, {2'h0, ch, 2'b01}, rsp);
    t0 = cyc;
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, {2'h0, ch, 2'b11}, rsp);
    rdreg(adc_ctrl_pkg::OFS_STATUS, rd, rsp);
    check(32'(rd[1]), 32'h1);
    // run bit kept, so the clock source stays the same.
    wr(adc_ctrl_pkg::OFS_POWER_MODE, {6'h0, mode}, rsp);
    wait_idle(took);
    took = cyc - t0;
    // The two-period wait after the end must pass before sampling resumes.
    do rdreg(adc_ctrl_pkg::OFS_STATUS, rd, rsp);
    while (rd[1] === 1'b1 && cyc - t0 < 20000);
    check(32'(sampleChannel), 32'(ch));
    check(32'(sampleEnable), 32'h1);
    check(rd[1:0], 2'b01);
    wr(adc_ctrl_pkg::OFS_STATUS, 8'h01, rsp);
    rdreg(adc_ctrl_pkg::OFS_STATUS, rd, rsp);
    check(32'(rd[0]), 32'h0);
    rdreg(adc_ctrl_pkg::OFS_RESULT_HIGH, rd, rsp);
    check(rd, timing[7] ? {30'h0, s[9:8]} : {24'h0, s[9:2]});
    rdreg(adc_ctrl_pkg::OFS_RESULT_LOW, rd, rsp);
    check(rd, timing[7] ? {24'h0, s[7:0]} : {24'h0, s[1:0], 6'h0});
  endtask : convert
  task automatic refused_start;
    wr(adc_ctrl_pkg::OFS_POWER_MODE, 8'h00, rsp);
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, 8'h03, rsp);
    rdreg(adc_ctrl_pkg::OFS_STATUS, rd, rsp);
    check(32'(rd[1]), 32'h0);
  endtask : refused_start
  task automatic clock_codes;
    logic [2:0] codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int took;
    int div;
    for (int i = 0; i < 7; i++) begin
      div = (i == 6) ? adc_ctrl_pkg::RC_DIVIDE : (2 << i);
      // last code picks the RC clock, as a slow or sleeping mode needs.
      wr(adc_ctrl_pkg::OFS_POWER_MODE, 8'h01, rsp);
      convert(4'(i + 2), {2'b10, 3'h0, codes[i]}, 2'b11, took);
      // Zero acquisition adds an instruction-cycle delay before the bit periods.
      check(32'(took >= 11 * div + adc_ctrl_pkg::INSTR_CYCLE_CLKS), 32'h1);
      check(32'(took < 14 * div + 40), 32'h1);
    end
  endtask : clock_codes
  task automatic calibrate;
    int took;
    wr(adc_ctrl_pkg::OFS_POWER_MODE, 8'h01, rsp);
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, 8'h01, rsp);
    wr(adc_ctrl_pkg::OFS_TIMING_CFG, 8'h48, rsp);
    wr(adc_ctrl_pkg::OFS_CHANNEL_RUN, 8'h03, rsp);
    rdreg(adc_ctrl_pkg::OFS_CHANNEL_RUN, rd, rsp);
    check(32'(rd[adc_ctrl_pkg::BIT_START]), 32'h1);
    wait_idle(took);
    check(32'(rd[adc_ctrl_pkg::BIT_START]), 32'h0);
    rdreg(adc_ctrl_pkg::OFS_STATUS, rd, rsp);
    check(32'(rd[2]), 32'h1);
    wr(adc_ctrl_pkg::OFS_TIMING_CFG, 8'h08, rsp);
  endtask : calibrate
  initial begin
    int took;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    reset_and_map();
    shared_map();
    refused_start();
    wr(adc_ctrl_pkg::OFS_POWER_MODE, 8'h01, rsp);
    convert(4'h3, 8'h89, 2'b11, took);
    wr(adc_ctrl_pkg::OFS_POWER_MODE, 8'h01, rsp);
    convert(4'h5, 8'h11, 2'b01, took);
    clock_codes();
    calibrate();
    complete_run();
  end
endmodule : adc_power_mode_and_calibration_control_test
`default_nettype wire
